// *** include/pubsub_rx_defines.vh ***
/*
 * Constants for the publish-subscribe message receiver: field positions,
 * reset values of the receiver context, submessage identifiers and error codes.
 * Assumes it is included by bare name from the rtl files.
 */
`ifndef PUBSUB_RX_DEFINES_VH
`define PUBSUB_RX_DEFINES_VH

// Message header layout (byte positions)
`define MHDR_LEN 32'h00000014
`define MHDR_VER_LO 5'h04
`define MHDR_VEN_LO 5'h06
`define MHDR_PFX_LO 5'h08
`define MHDR_LAST 5'h13
`define SHDR_LEN 32'h00000004
// Identifies a message of this protocol; value is arbitrary
`define PROTO_MAGIC 32'h50534d31

// Submessage flag positions
`define FLAG_E 0
`define FLAG_TS_INV 1

// Context reset values
`define PROTO_VERSION 16'h0202
`define VENDOR_UNKNOWN 16'h0000
`define PREFIX_UNKNOWN 96'h0
`define TIME_INVALID 64'hffffffffffffffff
`define LOC_PORT_INVALID 32'h00000000
`define LOC_ADDR_INVALID 128'h0

// Submessage identifiers
`define ID_PAD 8'h01
`define ID_ACKNACK 8'h02
`define ID_HB 8'h03
`define ID_GAP 8'h04
`define ID_INFO_TS 8'h05
`define ID_INFO_SRC 8'h06
`define ID_INFO_DST 8'h07
`define ID_INFO_REPLY 8'h08
`define ID_NACKFRAG 8'h09
`define ID_HBFRAG 8'h0a
`define ID_DATA 8'h0b
`define ID_DATAFRAG 8'h0c
`define ID_VEND_MIN 8'h80

// Least body lengths of known kinds
`define MIN_INFO_TS 16'h0008
`define MIN_INFO_SRC 16'h0014
`define MIN_INFO_DST 16'h000c
`define MIN_INFO_REPLY 16'h001c
`define MIN_ENDPOINT 16'h0008

// Error codes
`define ERR_NONE 3'h0
`define ERR_MAGIC 3'h1
`define ERR_SHORT_HDR 3'h2
`define ERR_BAD_LEN 3'h3
`define ERR_BAD_SUB 3'h4
`define ERR_TRUNC 3'h5

`endif

// *** rtl/word_assembler.v ***
/*
 * Builds a 32-bit word from a byte stream in either byte order.
 * Assumes bytes arrive one per valid cycle; word shows the value including
 * the current byte, so the caller can capture it in the same cycle.
 */
`timescale 1ns/1ps
module word_assembler (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Byte input
    input wire valid,
    input wire [7:0] data,
    input wire le,
    input wire start,
    // Assembled word
    output wire [31:0] word
);
    reg [31:0] acc_ff;
    wire [31:0] base = start ? 32'h0 : acc_ff;

    // Little-endian bytes enter at the top so the first lands lowest
    assign word = le ? {data, base[31:8]} : {base[23:0], data};

    always @(posedge clk) begin
        if (rst) begin
            acc_ff <= 32'h0;
        end else if (valid) begin
            acc_ff <= word;
        end
    end
endmodule // word_assembler

// *** rtl/submsg_classify.v ***
/*
 * Sorts a submessage header into context, endpoint or skipped kinds and
 * gives the least body length of a known kind.
 * Assumes id and flags are stable while the length bytes arrive.
 */
`timescale 1ns/1ps
`include "pubsub_rx_defines.vh"
module submsg_classify (
    // Submessage header
    input wire [7:0] id,
    input wire [7:0] flags,
    input wire vendor_ok,
    // Decoded class
    output reg [3:0] ctx_kind,
    output reg to_ep,
    output reg skip,
    output reg [15:0] min_len
);
    wire vend = (id >= `ID_VEND_MIN);

    always @* begin
        ctx_kind = 4'h0;
        to_ep = 1'b0;
        skip = 1'b0;
        min_len = 16'h0;
        case (id)
            `ID_INFO_TS: begin
                ctx_kind = 4'h1;
                min_len = flags[`FLAG_TS_INV] ? 16'h0 : `MIN_INFO_TS;
            end
            `ID_INFO_SRC: begin
                ctx_kind = 4'h2;
                min_len = `MIN_INFO_SRC;
            end
            `ID_INFO_DST: begin
                ctx_kind = 4'h4;
                min_len = `MIN_INFO_DST;
            end
            `ID_INFO_REPLY: begin
                ctx_kind = 4'h8;
                min_len = `MIN_INFO_REPLY;
            end
            `ID_DATA, `ID_DATAFRAG, `ID_HB, `ID_ACKNACK, `ID_GAP,
            `ID_HBFRAG, `ID_NACKFRAG: begin
                to_ep = 1'b1;
                min_len = `MIN_ENDPOINT;
            end
            `ID_PAD: begin
                skip = 1'b1;
            end
            default: begin
                // RQ9 vendor kinds
                to_ep = vend & vendor_ok;
                // RQ8 unknown kinds
                skip = ~(vend & vendor_ok);
            end
        endcase
    end
endmodule // submsg_classify

// *** rtl/pubsub_message_receiver.v ***
/*
 * Receive-side interpreter for publish-subscribe messages. Walks the
 * submessages of each message, keeps the receiver context and forwards
 * endpoint submessages as a byte stream.
 * Assumes message bytes arrive one per in_valid cycle from logic on clk,
 * with in_first on the first byte carrying the whole length on in_len.
 */
// Overview of operation
// RQ1 - Context from earlier submessages stays and steers later ones of a message.
// RQ2 - Message start resets version, vendor, source prefix and timestamp.
// RQ3 - Message start loads destination prefix with the local participant prefix.
// RQ4 - Unicast reply locator: transport kind, source address if known, invalid port.
// RQ5 - Multicast reply locator: transport kind, invalid address, invalid port.
// RQ6 - Too few bytes for a submessage header makes the rest invalid.
// RQ7 - An invalid length field discards the rest of the message.
// RQ8 - Unknown submessage kinds are skipped; parsing goes on.
// RQ9 - Vendor kinds from an unrecognised vendor are skipped; parsing goes on.
// RQ10 - Unknown and unused flag bits are ignored.
// RQ11 - The length field, not parsed content, finds the next submessage.
// RQ12 - A known submessage failing its checks invalidates the rest.
// RQ13 - Only header and info submessages change the receiver context.
// RQ14 - Endpoint submessages go to the endpoint, leaving context alone.
// RQ15 - Length zero means last submessage, running to message end.
// RQ16 - Length counts contents only; next header follows header plus length.
// RQ17 - Flag bit zero picks byte order of the submessage.
// RQ18 - Submessage header is id, flags and two length bytes in own order.
// RQ19 - A length reaching past the message end is invalid.
`timescale 1ns/1ps
`include "pubsub_rx_defines.vh"
module pubsub_message_receiver (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Message byte stream
    input wire in_valid,
    input wire [7:0] in_data,
    input wire in_first,
    input wire in_last,
    input wire [31:0] in_len,
    // Transport and local identity
    input wire [31:0] xport_kind,
    input wire src_addr_ok,
    input wire [127:0] src_addr,
    input wire [95:0] local_prefix,
    input wire [15:0] known_vendor,
    // Receiver context
    output reg [15:0] src_version_ff,
    output reg [15:0] src_vendor_ff,
    output reg [95:0] src_prefix_ff,
    output reg [95:0] dst_prefix_ff,
    output reg [31:0] uc_kind_ff,
    output reg [31:0] uc_port_ff,
    output reg [127:0] uc_addr_ff,
    output reg [31:0] mc_kind_ff,
    output reg [31:0] mc_port_ff,
    output reg [127:0] mc_addr_ff,
    output reg have_ts_ff,
    output reg [63:0] ts_ff,
    // Endpoint stream
    output reg ep_valid_ff,
    output reg [7:0] ep_data_ff,
    output reg ep_first_ff,
    output reg ep_last_ff,
    output reg [7:0] ep_kind_ff,
    output reg [7:0] ep_flags_ff,
    // Message events
    output reg busy_ff,
    output reg msg_done_ff,
    output reg skip_ff,
    output reg msg_err_ff,
    output reg [2:0] err_code_ff,
    output reg [15:0] sub_count_ff
);
    localparam S_IDLE = 5'h01;
    localparam S_MHDR = 5'h02;
    localparam S_SHDR = 5'h04;
    localparam S_BODY = 5'h08;
    localparam S_DROP = 5'h10;

    reg [4:0] state_ff;
    reg [4:0] pos_ff;
    reg [31:0] rem_ff;
    reg [31:0] blen_ff;
    reg [7:0] id_ff;
    reg [7:0] flg_ff;
    reg [7:0] lenlo_ff;
    reg [31:0] magic_ff;

    // A new message restarts the walk whatever state was left behind
    wire first = in_valid & in_first;
    wire [4:0] st = first ? S_MHDR : state_ff;
    wire [4:0] pos = first ? 5'h00 : pos_ff;
    wire [31:0] rem = first ? in_len : rem_ff;
    wire [31:0] rem_after = rem - 32'h1;
    wire [4:0] pos_inc = (pos == 5'h1f) ? pos : pos + 5'h01;
    wire [31:0] magic = {magic_ff[23:0], in_data};

    // RQ17 byte order
    wire le = flg_ff[`FLAG_E];
    // RQ18 length in own order
    wire [15:0] slen = le ? {in_data, lenlo_ff} : {lenlo_ff, in_data};
    // RQ15 zero length
    wire [31:0] body = (slen == 16'h0) ? rem_after : {16'h0, slen};
    // RQ19 past the end
    wire len_bad = ({16'h0, slen} > rem_after);

    wire [3:0] ctx_kind;
    wire to_ep;
    wire skip;
    wire [15:0] min_len;
    wire [31:0] word;
    // RQ9 vendor known
    wire vendor_ok = (src_vendor_ff == known_vendor) & (src_vendor_ff != `VENDOR_UNKNOWN);
    wire wstart = (pos[1:0] == 2'b00);

    // RQ10 only E and the timestamp invalidate flag are ever looked at
    submsg_classify u_classify (
        .id(id_ff),
        .flags(flg_ff),
        .vendor_ok(vendor_ok),
        .ctx_kind(ctx_kind),
        .to_ep(to_ep),
        .skip(skip),
        .min_len(min_len)
    );

    word_assembler u_word (
        .clk(clk),
        .rst(rst),
        .valid(in_valid),
        .data(in_data),
        .le(le),
        .start(wstart),
        .word(word)
    );

    always @(posedge clk) begin
        if (rst) begin
            state_ff <= S_IDLE;
            pos_ff <= 5'h00;
            rem_ff <= 32'h0;
            blen_ff <= 32'h0;
            id_ff <= 8'h00;
            flg_ff <= 8'h00;
            lenlo_ff <= 8'h00;
            magic_ff <= 32'h0;
            src_version_ff <= `PROTO_VERSION;
            src_vendor_ff <= `VENDOR_UNKNOWN;
            src_prefix_ff <= `PREFIX_UNKNOWN;
            dst_prefix_ff <= `PREFIX_UNKNOWN;
            uc_kind_ff <= 32'h0;
            uc_port_ff <= `LOC_PORT_INVALID;
            uc_addr_ff <= `LOC_ADDR_INVALID;
            mc_kind_ff <= 32'h0;
            mc_port_ff <= `LOC_PORT_INVALID;
            mc_addr_ff <= `LOC_ADDR_INVALID;
            have_ts_ff <= 1'b0;
            ts_ff <= `TIME_INVALID;
            ep_valid_ff <= 1'b0;
            ep_data_ff <= 8'h00;
            ep_first_ff <= 1'b0;
            ep_last_ff <= 1'b0;
            ep_kind_ff <= 8'h00;
            ep_flags_ff <= 8'h00;
            busy_ff <= 1'b0;
            msg_done_ff <= 1'b0;
            skip_ff <= 1'b0;
            msg_err_ff <= 1'b0;
            err_code_ff <= `ERR_NONE;
            sub_count_ff <= 16'h0;
        end else begin
            ep_valid_ff <= 1'b0;
            ep_first_ff <= 1'b0;
            ep_last_ff <= 1'b0;
            msg_done_ff <= 1'b0;
            skip_ff <= 1'b0;
            msg_err_ff <= 1'b0;
            if (in_valid && (st != S_IDLE)) begin
                rem_ff <= rem_after;
                pos_ff <= pos_inc;
                busy_ff <= 1'b1;
                case (st)
                    S_MHDR: begin
                        magic_ff <= magic;
                        if (pos == 5'h00) begin
                            // RQ2 context reset
                            src_version_ff <= `PROTO_VERSION;
                            src_vendor_ff <= `VENDOR_UNKNOWN;
                            src_prefix_ff <= `PREFIX_UNKNOWN;
                            have_ts_ff <= 1'b0;
                            ts_ff <= `TIME_INVALID;
                            // RQ3 local prefix
                            dst_prefix_ff <= local_prefix;
                            // RQ4 unicast reply
                            uc_kind_ff <= xport_kind;
                            uc_port_ff <= `LOC_PORT_INVALID;
                            uc_addr_ff <= src_addr_ok ? src_addr : `LOC_ADDR_INVALID;
                            // RQ5 multicast reply
                            mc_kind_ff <= xport_kind;
                            mc_port_ff <= `LOC_PORT_INVALID;
                            mc_addr_ff <= `LOC_ADDR_INVALID;
                            err_code_ff <= `ERR_NONE;
                            sub_count_ff <= 16'h0;
                            state_ff <= S_MHDR;
                            if (in_len < `MHDR_LEN) begin
                                state_ff <= S_DROP;
                                msg_err_ff <= 1'b1;
                                err_code_ff <= `ERR_SHORT_HDR;
                            end
                        end
                        // RQ13 header updates context
                        if (pos[4:1] == `MHDR_VER_LO >> 1) begin
                            src_version_ff <= {src_version_ff[7:0], in_data};
                        end
                        if (pos[4:1] == `MHDR_VEN_LO >> 1) begin
                            src_vendor_ff <= {src_vendor_ff[7:0], in_data};
                        end
                        if (pos >= `MHDR_PFX_LO) begin
                            src_prefix_ff <= {src_prefix_ff[87:0], in_data};
                        end
                        if (pos == 5'h03 && magic != `PROTO_MAGIC) begin
                            state_ff <= S_DROP;
                            msg_err_ff <= 1'b1;
                            err_code_ff <= `ERR_MAGIC;
                        end
                        if (pos == `MHDR_LAST) begin
                            state_ff <= S_SHDR;
                            pos_ff <= 5'h00;
                        end
                    end
                    S_SHDR: begin
                        if (pos == 5'h00) begin
                            id_ff <= in_data;
                            // RQ6 header incomplete
                            if (rem < `SHDR_LEN) begin
                                state_ff <= S_DROP;
                                msg_err_ff <= 1'b1;
                                err_code_ff <= `ERR_SHORT_HDR;
                            end
                        end
                        if (pos == 5'h01) begin
                            flg_ff <= in_data;
                        end
                        if (pos == 5'h02) begin
                            lenlo_ff <= in_data;
                        end
                        if (pos == 5'h03) begin
                            pos_ff <= 5'h00;
                            blen_ff <= body;
                            sub_count_ff <= sub_count_ff + 16'h0001;
                            if (len_bad) begin
                                // RQ7 bad length
                                state_ff <= S_DROP;
                                msg_err_ff <= 1'b1;
                                err_code_ff <= `ERR_BAD_LEN;
                            end else if (body < {16'h0, min_len}) begin
                                // RQ12 invalid known kind
                                state_ff <= S_DROP;
                                msg_err_ff <= 1'b1;
                                err_code_ff <= `ERR_BAD_SUB;
                            end else begin
                                skip_ff <= skip;
                                if (ctx_kind[0] && flg_ff[`FLAG_TS_INV]) begin
                                    have_ts_ff <= 1'b0;
                                    ts_ff <= `TIME_INVALID;
                                end
                                // RQ16 next header after body
                                state_ff <= (body == 32'h0) ? S_SHDR : S_BODY;
                            end
                        end
                    end
                    S_BODY: begin
                        // RQ11 length walks the body
                        blen_ff <= blen_ff - 32'h1;
                        if (blen_ff == 32'h1) begin
                            state_ff <= S_SHDR;
                            pos_ff <= 5'h00;
                        end
                        // RQ14 endpoint delivery
                        if (to_ep) begin
                            ep_valid_ff <= 1'b1;
                            ep_data_ff <= in_data;
                            ep_first_ff <= (pos_ff == 5'h00);
                            ep_last_ff <= (blen_ff == 32'h1);
                            ep_kind_ff <= id_ff;
                            ep_flags_ff <= flg_ff;
                        end
                        // RQ1 context kept for later submessages
                        if (ctx_kind[0] && !flg_ff[`FLAG_TS_INV]) begin
                            if (pos_ff == 5'h03) begin
                                ts_ff[63:32] <= word;
                            end
                            if (pos_ff == 5'h07) begin
                                ts_ff[31:0] <= word;
                                have_ts_ff <= 1'b1;
                            end
                        end
                        // RQ13 info submessages update context
                        if (ctx_kind[1]) begin
                            if (pos_ff[4:1] == 4'h2) begin
                                src_version_ff <= {src_version_ff[7:0], in_data};
                            end
                            if (pos_ff[4:1] == 4'h3) begin
                                src_vendor_ff <= {src_vendor_ff[7:0], in_data};
                            end
                            if (pos_ff >= 5'h08 && pos_ff <= 5'h13) begin
                                src_prefix_ff <= {src_prefix_ff[87:0], in_data};
                            end
                        end
                        if (ctx_kind[2] && pos_ff <= 5'h0b) begin
                            dst_prefix_ff <= {dst_prefix_ff[87:0], in_data};
                        end
                        // Only the first unicast locator is kept
                        if (ctx_kind[3]) begin
                            if (pos_ff == 5'h07) begin
                                uc_kind_ff <= word;
                            end
                            if (pos_ff == 5'h0b) begin
                                uc_port_ff <= word;
                            end
                            if (pos_ff >= 5'h0c && pos_ff <= 5'h1b) begin
                                uc_addr_ff <= {uc_addr_ff[119:0], in_data};
                            end
                        end
                    end
                    default: begin
                        state_ff <= S_DROP;
                    end
                endcase
                // End of message by count or by the stream's own marker
                if (rem_after == 32'h0 || in_last) begin
                    state_ff <= S_IDLE;
                    busy_ff <= 1'b0;
                    msg_done_ff <= 1'b1;
                    if (rem_after != 32'h0 && st != S_DROP) begin
                        msg_err_ff <= 1'b1;
                        err_code_ff <= `ERR_TRUNC;
                    end
                end
            end
        end
    end
endmodule // pubsub_message_receiver

// *** tb/rx_asserts.sv ***
/* Checker on the message receiver ports.
   Bound into the receiver from the testbench top file. */
`timescale 1ns/1ps
`include "pubsub_rx_defines.vh"
module rx_asserts (
    input logic clk, rst, in_valid, in_first, src_addr_ok, have_ts_ff, ep_valid_ff,
    input logic busy_ff, msg_done_ff, skip_ff, msg_err_ff,
    input logic [2:0] err_code_ff,
    input logic [7:0] ep_kind_ff,
    input logic [15:0] known_vendor, src_version_ff, src_vendor_ff, sub_count_ff,
    input logic [31:0] xport_kind, uc_kind_ff, uc_port_ff, mc_kind_ff, mc_port_ff,
    input logic [63:0] ts_ff,
    input logic [95:0] local_prefix, src_prefix_ff, dst_prefix_ff,
    input logic [127:0] src_addr, uc_addr_ff, mc_addr_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire sb = !rst && in_valid && in_first;
    logic dead_ff;
    // An errored message must stay silent until the next one starts
    always_ff @(posedge clk) dead_ff <= !(rst || sb) && (dead_ff || msg_err_ff);
    chk_start_ctx: assert property (sb |=> src_version_ff == `PROTO_VERSION
        && src_vendor_ff == `VENDOR_UNKNOWN && src_prefix_ff == `PREFIX_UNKNOWN
        && !have_ts_ff && ts_ff == `TIME_INVALID) else $error("context not reset");
    chk_start_dest: assert property (sb |=>
        dst_prefix_ff == $past(local_prefix)) else $error("dest prefix not loaded");
    chk_start_uc: assert property (sb |=> uc_kind_ff == $past(xport_kind)
        && uc_port_ff == `LOC_PORT_INVALID && uc_addr_ff == ($past(src_addr_ok)
        ? $past(src_addr) : `LOC_ADDR_INVALID)) else $error("unicast locator wrong");
    chk_start_mc: assert property (sb |=> mc_kind_ff == $past(xport_kind)
        && mc_port_ff == `LOC_PORT_INVALID && mc_addr_ff == `LOC_ADDR_INVALID)
        else $error("multicast locator wrong");
    chk_err_code: assert property (msg_err_ff |-> err_code_ff != `ERR_NONE
        && err_code_ff <= `ERR_TRUNC) else $error("error without cause");
    chk_dead_quiet: assert property (dead_ff |-> !ep_valid_ff && !skip_ff)
        else $error("output after error");
    chk_skip_quiet: assert property (skip_ff |-> !ep_valid_ff [*5])
        else $error("skipped body forwarded");
    chk_ep_kind: assert property (ep_valid_ff |-> ep_kind_ff inside {8'h02, 8'h03,
        8'h04, 8'h09, 8'h0a, 8'h0b, 8'h0c} || (ep_kind_ff >= `ID_VEND_MIN
        && src_vendor_ff == known_vendor && known_vendor != 16'h0000))
        else $error("wrong kind forwarded");
    chk_ep_ctx: assert property (ep_valid_ff |-> $stable(ts_ff)
        && $stable(dst_prefix_ff) && $stable(src_vendor_ff))
        else $error("endpoint byte changed context");
    chk_done_idle: assert property (msg_done_ff |-> !busy_ff)
        else $error("busy at message end");
    chk_count_step: assert property (sub_count_ff != $past(sub_count_ff) |->
        sub_count_ff == $past(sub_count_ff) + 16'h0001 || sub_count_ff == 16'h0000)
        else $error("submessage count jumped");
    cover property (ep_valid_ff && ep_kind_ff >= `ID_VEND_MIN);
    cover property (skip_ff);
    cover property (msg_err_ff && err_code_ff == `ERR_BAD_LEN);
endmodule // rx_asserts

// *** tb/msg_source.sv ***
/* Remote participant model: streams one queued message a byte per cycle
   with random idle gaps. Assumes the bench fills q after reset. */
`timescale 1ns/1ps
module msg_source (
    // Clock
    input logic clk,
    // Message stream
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_first,
    output logic in_last,
    output logic [31:0] in_len
);
    logic [7:0] q[$];
    int seed = 32'h356a;
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_first = 1'b0;
        in_last = 1'b0;
        in_len = 32'h0;
    end
    // Idle data flips so a stale byte never looks live
    task automatic idle();
        @(posedge clk);
        in_valid <= 1'b0;
        in_first <= 1'b0;
        in_last <= 1'b0;
        in_data <= ~in_data;
    endtask
    task automatic send();
        int n;
        n = q.size();
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            in_valid <= 1'b1;
            in_data <= q[i];
            in_first <= i == 0;
            in_last <= i == n - 1;
            in_len <= 32'(n);
            if ($random(seed) % 4 == 0 && i != n - 1)
                idle();
        end
        idle();
        q.delete();
    endtask
endmodule // msg_source

// *** tb/testbench.sv ***
/* Bench for the message receiver; assumes the source model and checker. */
`timescale 1ns/1ps
`include "pubsub_rx_defines.vh"
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] xport_kind = 32'h0;
    logic src_addr_ok = 1'b0;
    logic [127:0] src_addr = 128'h0;
    logic [95:0] local_prefix = 96'h0;
    logic [15:0] known_vendor = 16'h00a5;
    wire in_valid, in_first, in_last, have_ts_ff, ep_valid_ff, busy_ff, skip_ff;
    wire [7:0] in_data, ep_data_ff;
    wire [31:0] in_len, uc_kind_ff, uc_port_ff, mc_kind_ff, mc_port_ff;
    wire [15:0] src_version_ff, src_vendor_ff, sub_count_ff;
    wire [95:0] dst_prefix_ff;
    wire [127:0] uc_addr_ff, mc_addr_ff;
    wire [2:0] err_code_ff;
    logic [2:0] ec[5] = '{`ERR_NONE, `ERR_NONE, `ERR_BAD_SUB, `ERR_BAD_LEN, `ERR_SHORT_HDR};
    logic [7:0] exp_q[$];
    int seed = 32'h356a, n_errors = 0, samples_checked = 0, ep_n, exp_n, skip_n;
    always #10 clk = ~clk;
    msg_source src_u (.clk(clk), .in_valid(in_valid), .in_data(in_data),
        .in_first(in_first), .in_last(in_last), .in_len(in_len));
    pubsub_message_receiver dut_u (.*, .src_prefix_ff(), .ts_ff(), .ep_first_ff(),
        .ep_last_ff(), .ep_kind_ff(), .ep_flags_ff(), .msg_done_ff(), .msg_err_ff());
    task automatic check(input string nm, input logic [127:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (ep_valid_ff === 1'b1) begin
            ep_n++;
            check("ep_data", ep_data_ff, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
        if (skip_ff === 1'b1)
            skip_n++;
    end
    task automatic put(input logic [7:0] b);
        src_u.q.push_back(b);
    endtask
    task automatic sub(input logic [7:0] id, input logic [7:0] fl, input logic [15:0] len,
        input int nb, input bit fwd);
        logic [7:0] b;
        put(id);
        put(fl);
        put(fl[0] ? len[7:0] : len[15:8]);
        put(fl[0] ? len[15:8] : len[7:0]);
        repeat (nb) begin
            b = 8'($random(seed));
            put(b);
            if (fwd) begin
                exp_q.push_back(b);
                exp_n++;
            end
        end
    endtask
    task automatic msg(input int k);
        logic [15:0] ven;
        int t;
        ep_n = 0;
        exp_n = 0;
        skip_n = 0;
        ven = k == 1 ? 16'h0077 : known_vendor;
        @(posedge clk);
        xport_kind <= $random(seed);
        src_addr_ok <= k[0];
        src_addr <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        local_prefix <= {$random(seed), $random(seed), $random(seed)};
        for (t = 0; t < 4; t++)
            put(8'(`PROTO_MAGIC >> (24 - 8 * t)));
        put(8'h02);
        put(8'h03);
        put(ven[15:8]);
        put(ven[7:0]);
        repeat (12) put(8'($random(seed)));
        case (k)
            0: begin
                sub(`ID_INFO_TS, 8'h01, 16'h0008, 8, 0);
                sub(`ID_DATA, 8'hf0, 16'h000c, 12, 1);
                sub(8'h80, 8'h01, 16'h0004, 4, 1);
            end
            1: begin
                sub(8'h20, 8'h01, 16'h0004, 4, 0);
                sub(8'h81, 8'h00, 16'h0004, 4, 0);
                sub(`ID_DATA, 8'h01, 16'h0000, 10, 1);
            end
            2: begin
                sub(`ID_INFO_DST, 8'h00, 16'h0004, 4, 0);
                sub(`ID_DATA, 8'h00, 16'h0008, 8, 0);
            end
            3: sub(`ID_HB, 8'h00, 16'h0064, 8, 0);
            default: begin
                sub(`ID_ACKNACK, 8'h01, 16'h0008, 8, 1);
                put(8'h00);
                put(8'h00);
            end
        endcase
        src_u.send();
        @(posedge clk);
        for (t = 0; t < 40 && busy_ff !== 1'b0; t++)
            @(posedge clk);
        if (t == 40) begin
            n_errors++;
            print_verdict();
        end
        @(posedge clk);
        check("ep_count", ep_n, exp_n);
        check("ep_left", exp_q.size(), 0);
        check("skips", skip_n, k == 1 ? 2 : 0);
        check("err_code", err_code_ff, ec[k]);
        check("uc_addr", uc_addr_ff, k[0] ? src_addr : 128'h0);
        check("uc_kind", uc_kind_ff, xport_kind);
        check("uc_port", uc_port_ff, `LOC_PORT_INVALID);
        check("mc_addr", mc_addr_ff, `LOC_ADDR_INVALID);
        check("mc_kind", mc_kind_ff, xport_kind);
        check("vendor", src_vendor_ff, ven);
        check("version", src_version_ff, 16'h0203);
        if (k < 2) begin
            check("subs", sub_count_ff, 3);
            check("have_ts", have_ts_ff, k == 0);
            check("dst", dst_prefix_ff, local_prefix);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++)
            msg(k);
        print_verdict();
    end
endmodule // testbench
bind pubsub_message_receiver rx_asserts chk_u (.*);
